// File: bench/ctm_can_peer.sv
// far side: protocol controller on txd and the rest of the bus on bus_rx
// assumes the bench steers both nodes; recessive bus idles high
`timescale 1ns/1ps
module ctm_can_peer (
  input wire logic pclk,
  input wire logic ctl_dom,
  input wire logic node_dom,
  input wire logic tx_enable,
  output logic txd,
  output logic bus_rx
);
  // controller pin; a stuck-low txd is commanded by the bench on purpose
  always_comb begin
    txd = !ctl_dom;
  end
  // wired dominant: our driver only counts while the device enables it
  always_comb begin
    bus_rx = !(node_dom || (tx_enable && !txd));
  end
endmodule : ctm_can_peer

// File: bench/ctm_mode_ctrl_props.sv
// concurrent checks on the pins of the transceiver mode controller
// assumes one pclk domain and an active-low asynchronous presetn
`timescale 1ns/1ps
module ctm_props import ctm_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] chip_mode_control,
  input wire logic bat_undervoltage,
  input wire logic txd,
  input wire logic bus_rx,
  input wire logic high_voltage_switch_output,
  input wire logic sensor_supply_output,
  input wire logic tx_enable,
  input wire logic bias_2v5,
  input wire logic bias_gnd,
  input wire logic transceiver_on,
  input wire logic rxd_force_low,
  input wire logic sleep_wake_request
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered after one wait");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  a_off_floats: assert property (
    (chip_mode_control == CTM_CHIP_OFF || bat_undervoltage) [*4] |-> !transceiver_on)
    else $error("transceiver on in off condition");
  a_float_idle: assert property (!transceiver_on |-> !(tx_enable || bias_2v5 || bias_gnd))
    else $error("bus driven while off");
  a_standby_no_tx: assert property ((chip_mode_control == CTM_CHIP_STANDBY) [*4] |-> !tx_enable)
    else $error("transmitter on in standby");
  a_txd_blocks: assert property ((!txd) [*4] |-> !$rose(tx_enable))
    else $error("active entered with txd low");
  a_tx_bias: assert property (tx_enable |-> bias_2v5 && !bias_gnd)
    else $error("active without mid bias");
  a_ot_sens_off: assert property (
    (chip_mode_control == CTM_CHIP_OVERTEMP) [*4] |-> !sensor_supply_output)
    else $error("sensor supply on in overtemp");
  a_ot_hv_hold: assert property (
    (chip_mode_control == CTM_CHIP_OVERTEMP) [*4] |=> $stable(high_voltage_switch_output))
    else $error("hv switch moved in overtemp");
  a_wake_on_dom: assert property ($rose(rxd_force_low) |-> !$past(bus_rx) || !$past(bus_rx, 2))
    else $error("wake without dominant bus");
  a_sleep_pulse: assert property (sleep_wake_request |=> !sleep_wake_request)
    else $error("sleep wake request too long");
endmodule : ctm_props

bind ctm_mode_ctrl ctm_props props_u (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .chip_mode_control, .bat_undervoltage, .txd, .bus_rx, .high_voltage_switch_output,
  .sensor_supply_output, .tx_enable, .bias_2v5, .bias_gnd, .transceiver_on, .rxd_force_low,
  .sleep_wake_request);

// File: bench/ctm_mode_ctrl_tb.sv
// self-checking bench for the transceiver mode controller
// assumes 100 MHz pclk; silence and wake timeouts shortened to 200/400
`timescale 1ns/1ps
module ctm_mode_ctrl_tb import ctm_pkg::*;;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, txd, bus_rx, hv, sens, tx_en, b25, bgnd, t_on, rxd_lo, swr;
  logic [2:0] chip = CTM_CHIP_STANDBY;
  logic [1:0] boot = 2'h3;
  logic sup = 1'b1, batuv = 1'b0, ctl_dom = 1'b0, node_dom = 1'b0;
  logic [2:0] mlist [4] = '{CTM_CHIP_RESET, CTM_CHIP_STANDBY, CTM_CHIP_SLEEP, CTM_CHIP_NORMAL};
  int n_fail = 0, n_tests = 0, cyc = 0, n_swr = 0;

  ctm_mode_ctrl #(.SILENCE_CYC(20'h000C8), .WAKE_TO_CYC(20'h00190)) dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .chip_mode_control(chip), .ext_output_startup_config(boot), .mcu_supply_ok(sup),
    .bat_undervoltage(batuv), .txd, .bus_rx, .high_voltage_switch_output(hv),
    .sensor_supply_output(sens), .tx_enable(tx_en), .bias_2v5(b25), .bias_gnd(bgnd),
    .transceiver_on(t_on), .rxd_force_low(rxd_lo), .sleep_wake_request(swr));
  ctm_can_peer peer_u (.pclk, .ctl_dom, .node_dom, .tx_enable(tx_en), .txd, .bus_rx);

  // free-running clock
  initial begin
    forever #5 pclk = ~pclk;
  end
  // run limit and a tally of sleep wake pulses
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (swr === 1'b1) n_swr <= n_swr + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // one transfer, request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no fixed wait assumed; only the run limit ends a hang
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic st(input logic [4:0] s);
    apb(1'b0, CTM_STATUS_ADDR, 32'h0);
    chk({27'h0, rd[CTM_ST_STATE_LSB +: 5]}, {27'h0, s});
  endtask : st

  // mode pins change after an edge; state and outputs follow within a few edges
  task automatic pins(input logic [2:0] m, input logic ok);
    @(posedge pclk);
    chip <= m;
    sup <= ok;
    repeat (4) @(posedge pclk);
  endtask : pins

  // dominant, recessive, dominant of 60 cycles each, well inside the timeout
  task automatic wake();
    @(posedge pclk);
    repeat (3) begin
      node_dom <= !node_dom;
      repeat (60) @(posedge pclk);
    end
    node_dom <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : wake

  function automatic logic hv_exp(input logic [1:0] c, input logic [2:0] m);
    case (c)
      CTM_OUT_NORMAL: return m == CTM_CHIP_NORMAL;
      CTM_OUT_AWAKE: return m != CTM_CHIP_SLEEP;
      CTM_OUT_ALWAYS: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : hv_exp

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CTM_OUTCFG_ADDR, 32'h0);
    chk(rd, 32'h3);
    st(5'h02);
    // every output code in reset, standby, sleep and normal
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, CTM_OUTCFG_ADDR, 32'(c));
      foreach (mlist[i]) begin
        pins(mlist[i], 1'b1);
        chk({30'h0, hv, sens}, {30'h0, {2{hv_exp(2'(c), mlist[i])}}});
      end
    end
    pins(CTM_CHIP_OVERTEMP, 1'b1);
    apb(1'b1, CTM_OUTCFG_ADDR, 32'h0);
    repeat (3) @(posedge pclk);
    chk({30'h0, hv, sens}, 32'h2);
    pins(CTM_CHIP_RESET, 1'b1);
    st(5'h02);
    chk({31'h0, hv}, 32'h0);
    pins(CTM_CHIP_OFF, 1'b1);
    st(5'h01);
    pins(CTM_CHIP_RESET, 1'b1);
    st(5'h02);
    batuv <= 1'b1;
    repeat (5) @(posedge pclk);
    chk({31'h0, t_on}, 32'h0);
    batuv <= 1'b0;
    pins(CTM_CHIP_STANDBY, 1'b1);
    wake();
    apb(1'b0, CTM_STATUS_ADDR, 32'h0);
    chk(rd & 32'h4, 32'h0);
    repeat (260) @(posedge pclk);
    st(5'h02);
    chk({31'h0, bgnd}, 32'h1);
    apb(1'b1, CTM_CANCTRL_ADDR, 32'h4);
    wake();
    chk({31'h0, rxd_lo}, 32'h1);
    apb(1'b0, CTM_STATUS_ADDR, 32'h0);
    chk(rd & 32'h4, 32'h4);
    apb(1'b1, CTM_STATUS_ADDR, 32'h4);
    repeat (2) @(posedge pclk);
    chk({31'h0, rxd_lo}, 32'h0);
    pins(CTM_CHIP_SLEEP, 1'b1);
    wake();
    chk(32'(n_swr), 32'h1);
    apb(1'b1, CTM_CANCTRL_ADDR, 32'h1);
    pins(CTM_CHIP_NORMAL, 1'b1);
    st(5'h10);
    chk({30'h0, tx_en, rd[CTM_ST_TX_READY_BIT]}, 32'h3);
    pins(CTM_CHIP_NORMAL, 1'b0);
    chk({30'h0, tx_en, b25}, 32'h1);
    st(5'h08);
    apb(1'b1, CTM_CANCTRL_ADDR, 32'h2);
    pins(CTM_CHIP_NORMAL, 1'b1);
    pins(CTM_CHIP_NORMAL, 1'b0);
    st(5'h10);
    pins(CTM_CHIP_RESET, 1'b0);
    st(5'h04);
    pins(CTM_CHIP_FORCED, 1'b1);
    st(5'h10);
    pins(CTM_CHIP_FORCED, 1'b0);
    st(5'h08);
    pins(CTM_CHIP_NORMAL, 1'b1);
    apb(1'b1, CTM_CANCTRL_ADDR, 32'h3);
    st(5'h08);
    chk({30'h0, tx_en, b25}, 32'h1);
    apb(1'b1, CTM_CANCTRL_ADDR, 32'h0);
    st(5'h04);
    ctl_dom <= 1'b1;
    apb(1'b1, CTM_CANCTRL_ADDR, 32'h1);
    st(5'h08);
    ctl_dom <= 1'b0;
    st(5'h10);
    pins(CTM_CHIP_STANDBY, 1'b1);
    st(5'h04);
    apb(1'b1, CTM_CANCTRL_ADDR, 32'h2);
    st(5'h04);
    apb(1'b0, 12'h00C, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    // mid-run reset: pins clear, state restarts, startup config reloads
    boot <= 2'h1;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({24'h0, hv, sens, tx_en, b25, bgnd, t_on, rxd_lo, swr}, 32'h0);
    presetn <= 1'b1;
    apb(1'b0, CTM_OUTCFG_ADDR, 32'h0);
    chk(rd, 32'h1);
    st(5'h02);
    end_of_test();
  end
endmodule : ctm_mode_ctrl_tb

// File: hdl/ctm_mode_ctrl.sv
// CAN transceiver mode controller with bus wake filter and output switches
// assumes synchronous pins, an APB master on pclk, bus_rx low = dominant
`timescale 1ns/1ps

// What this block does
// - drive hv switch per output configuration
// - config codes off/normal/awake/always on
// - hv switch holds state in overtemp
// - sensor supply off in overtemp
// - load output config from startup bits
// - mode select codes, effective in normal
// - standby or sleep forces offline operation
// - active on normal select 01/10, supply good
// - low transmit pin holds listen-only
// - supply drop in active (select 01) passes offline bias into listen-only
// - forced normal supply drop goes listen-only
// - select 10 keeps active through undervoltage
// - status shows transmitter ready
// - listen-only: transmitter off, bias on
// - three causes of listen-only
// - offline grounds bus, wakes if enabled
// - activity to bias, silence back offline
// - leave active/listen to bias on mode
// - off/overtemp into reset gives offline
// - wake or undervoltage request leaves offline
// - off, overtemp, battery low: fully off
// - wake needs dominant recessive dominant in time
// - wake sets event, rxd low, sleep wakes
module ctm_mode_ctrl import ctm_pkg::*; #(
  parameter logic [19:0] SILENCE_CYC = CTM_SILENCE_CYC,
  parameter logic [19:0] WAKE_TO_CYC = CTM_WAKE_TO_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] chip_mode_control,
  input wire logic [1:0] ext_output_startup_config,
  input wire logic mcu_supply_ok,
  input wire logic bat_undervoltage,
  input wire logic txd,
  input wire logic bus_rx,
  output logic high_voltage_switch_output,
  output logic sensor_supply_output,
  output logic tx_enable,
  output logic bias_2v5,
  output logic bias_gnd,
  output logic transceiver_on,
  output logic rxd_force_low,
  output logic sleep_wake_request
);

  typedef struct packed {
    // transceiver and wake filter state
    ctm_tstate_t tst;
    ctm_wstate_t wst;
    // bus timing
    logic [19:0] lvl_cnt;
    logic [19:0] wake_tmr;
    logic [19:0] sil_cnt;
    logic silent;
    logic rx_prev;
    logic [2:0] chip_prev;
    // register fields
    logic load_pend;
    logic [1:0] ext_output_config;
    logic [1:0] transceiver_mode_select;
    logic bus_wake_detect_enable;
    logic bus_wake_event;
    // registered pins
    logic hv_out;
    logic sens_out;
    logic rxd_low;
    logic wake_req;
    logic tx_on;
    logic bias_mid;
    logic bias_low;
    logic xcvr_on;
    // bus register answer
    logic [31:0] rdata;
    logic rdy;
    logic err;
  } ctm_state_t;

  ctm_state_t st_ff;
  ctm_state_t nxt_st;

  logic normal;
  logic forced;
  logic chip_off;
  logic chip_ot;
  logic chip_reset;
  logic chip_standby;
  logic chip_sleep;
  logic off_cond;
  logic reset_entry;
  logic uv_online;
  logic sel_listen;
  logic sel_offline;
  logic wake_watch;
  logic sel_act;
  logic act_req;
  logic listen_req;
  logic leave_req;
  logic edge_seen;
  logic wake_hit;
  logic access;
  logic wr;
  logic hit_out;
  logic hit_can;
  logic hit_st;
  logic hv_on;
  logic [31:0] rd_mux;

  // mode decode shared by the transceiver state machine
  always_comb begin
    normal = (chip_mode_control == CTM_CHIP_NORMAL);
    forced = (chip_mode_control == CTM_CHIP_FORCED);
    chip_off = (chip_mode_control == CTM_CHIP_OFF);
    chip_ot = (chip_mode_control == CTM_CHIP_OVERTEMP);
    chip_reset = (chip_mode_control == CTM_CHIP_RESET);
    chip_standby = (chip_mode_control == CTM_CHIP_STANDBY);
    chip_sleep = (chip_mode_control == CTM_CHIP_SLEEP);
    // select field decode
    sel_act = (st_ff.transceiver_mode_select == CTM_SEL_ACT_UV) ||
              (st_ff.transceiver_mode_select == CTM_SEL_ACT_NOUV);
    sel_listen = (st_ff.transceiver_mode_select == CTM_SEL_LISTEN);
    sel_offline = (st_ff.transceiver_mode_select == CTM_SEL_OFFLINE);
    // select field only counts in normal mode
    act_req = (normal && sel_act && mcu_supply_ok) || (forced && mcu_supply_ok);
    // online request that the supply cannot carry
    uv_online = normal && sel_act && !mcu_supply_ok;
    listen_req = (normal && sel_listen) || (forced && !mcu_supply_ok) || uv_online;
    // other chip modes drop active/listen, standby and sleep never go online
    leave_req = !(normal || forced) || (normal && sel_offline);
    // off conditions beat every other transition
    off_cond = chip_off || chip_ot || bat_undervoltage;
    // a start from off or overtemp passes through reset
    reset_entry = chip_reset && (st_ff.chip_prev == CTM_CHIP_OFF ||
                                 st_ff.chip_prev == CTM_CHIP_OVERTEMP);
    // wake filter listens only in the two offline states, and only when enabled
    wake_watch = st_ff.bus_wake_detect_enable &&
                 (st_ff.tst == CTM_T_OFFLINE || st_ff.tst == CTM_T_OBIAS);
    edge_seen = (bus_rx != st_ff.rx_prev);
  end

  // output switch decode for the configured chip modes; forced normal counts as normal
  always_comb begin
    case (st_ff.ext_output_config)
      CTM_OUT_NEVER: hv_on = 1'b0;
      CTM_OUT_NORMAL: hv_on = normal || forced;
      // standby and reset keep external loads supplied
      CTM_OUT_AWAKE: hv_on = normal || forced || chip_standby || chip_reset;
      // sleep as well, for loads that must outlive the mcu supply
      CTM_OUT_ALWAYS: hv_on = normal || forced || chip_standby || chip_reset || chip_sleep;
      default: hv_on = 1'b0;
    endcase
  end

  // apb decode; one wait state, access completes on the cycle after the first penable
  always_comb begin
    access = psel && penable && !st_ff.rdy;
    wr = access && pwrite;
    hit_out = (paddr == CTM_OUTCFG_ADDR);
    hit_can = (paddr == CTM_CANCTRL_ADDR);
    hit_st = (paddr == CTM_STATUS_ADDR);
    // unmapped offsets read as zero
    rd_mux = 32'h0;
    if (hit_out) begin
      rd_mux[1:0] = st_ff.ext_output_config;
    end else if (hit_can) begin
      rd_mux[1:0] = st_ff.transceiver_mode_select;
      rd_mux[CTM_CANCTRL_WAKE_EN_BIT] = st_ff.bus_wake_detect_enable;
    end else if (hit_st) begin
      rd_mux[CTM_ST_TX_READY_BIT] = (st_ff.tst == CTM_T_ACTIVE);
      rd_mux[CTM_ST_SILENT_BIT] = st_ff.silent;
      rd_mux[CTM_ST_WAKE_EV_BIT] = st_ff.bus_wake_event;
      rd_mux[CTM_ST_STATE_LSB +: 5] = st_ff.tst;
    end
  end

  // next state of everything
  always_comb begin
    nxt_st = st_ff;
    wake_hit = 1'b0;
    nxt_st.rx_prev = bus_rx;
    nxt_st.chip_prev = chip_mode_control;
    nxt_st.wake_req = 1'b0;

    // bus register interface
    nxt_st.rdy = access;
    nxt_st.err = access && !(hit_out || hit_can || hit_st);
    nxt_st.rdata = access && !pwrite ? rd_mux : 32'h0;
    if (wr && hit_out) begin
      nxt_st.ext_output_config = pwdata[1:0];
    end
    if (wr && hit_can) begin
      nxt_st.transceiver_mode_select = pwdata[1:0];
      nxt_st.bus_wake_detect_enable = pwdata[CTM_CANCTRL_WAKE_EN_BIT];
    end
    // startup bits loaded once after reset; a write in that cycle loses
    if (st_ff.load_pend) begin
      nxt_st.ext_output_config = ext_output_startup_config;
      nxt_st.load_pend = 1'b0;
    end

    // silence timer, restarted by any bus edge
    if (edge_seen) begin
      nxt_st.sil_cnt = 20'h0;
      nxt_st.silent = 1'b0;
    end else if (st_ff.sil_cnt >= SILENCE_CYC) begin
      nxt_st.silent = 1'b1;
    end else begin
      nxt_st.sil_cnt = st_ff.sil_cnt + 20'h1;
    end

    // wake filter; short glitches reset the level timer but keep the phase
    if (!wake_watch) begin
      nxt_st.wst = CTM_W_IDLE;
    end else begin
      nxt_st.lvl_cnt = st_ff.lvl_cnt + 20'h1;
      nxt_st.wake_tmr = st_ff.wake_tmr + 20'h1;
      case (st_ff.wst)
        // first dominant sample opens the window
        CTM_W_IDLE: begin
          nxt_st.lvl_cnt = 20'h0;
          nxt_st.wake_tmr = 20'h0;
          if (!bus_rx) begin
            nxt_st.wst = CTM_W_DOM1;
          end
        end
        // dominant phase must reach its minimum before recessive counts
        CTM_W_DOM1: begin
          if (bus_rx) begin
            nxt_st.lvl_cnt = 20'h0;
            if (st_ff.lvl_cnt + 20'h1 >= CTM_WAKE_DOM_CYC) begin
              nxt_st.wst = CTM_W_REC;
            end
          end
        end
        // recessive phase, same minimum rule
        CTM_W_REC: begin
          if (!bus_rx) begin
            nxt_st.lvl_cnt = 20'h0;
            if (st_ff.lvl_cnt + 20'h1 >= CTM_WAKE_REC_CYC) begin
              nxt_st.wst = CTM_W_DOM2;
            end
          end
        end
        // recessive glitches restart the closing dominant count
        CTM_W_DOM2: begin
          if (bus_rx) begin
            nxt_st.lvl_cnt = 20'h0;
          end else if (st_ff.lvl_cnt + 20'h1 >= CTM_WAKE_DOM_CYC) begin
            wake_hit = 1'b1;
            nxt_st.wst = CTM_W_IDLE;
          end
        end
        default: nxt_st.wst = CTM_W_IDLE;
      endcase
      // pattern must finish inside the wake window
      if (st_ff.wst != CTM_W_IDLE && !wake_hit && st_ff.wake_tmr >= WAKE_TO_CYC) begin
        nxt_st.wst = CTM_W_IDLE;
      end
    end

    // wake event: set wins over a software clear in the same cycle
    if (wr && hit_st && pwdata[CTM_ST_WAKE_EV_BIT]) begin
      nxt_st.bus_wake_event = 1'b0;
    end
    if (wake_hit) begin
      nxt_st.bus_wake_event = 1'b1;
      nxt_st.wake_req = chip_sleep;
    end
    nxt_st.rxd_low = nxt_st.bus_wake_event;

    // transceiver mode machine, the single state register
    case (st_ff.tst)
      CTM_T_OFF: nxt_st.tst = CTM_T_OFFLINE;
      // offline pair: online requests first, then bus activity or silence
      CTM_T_OFFLINE, CTM_T_OBIAS: begin
        if (act_req) begin
          nxt_st.tst = txd ? CTM_T_ACTIVE : CTM_T_LISTEN;
        end else if (listen_req && !(st_ff.tst == CTM_T_OFFLINE && sel_act)) begin
          nxt_st.tst = CTM_T_LISTEN;
        end else if (st_ff.tst == CTM_T_OFFLINE) begin
          if (wake_hit || edge_seen || uv_online) begin
            nxt_st.tst = CTM_T_OBIAS;
          end
        end else if (st_ff.silent) begin
          nxt_st.tst = CTM_T_OFFLINE;
        end
      end
      // listen: leave on a mode change, go active once txd is high
      CTM_T_LISTEN: begin
        if (leave_req) begin
          nxt_st.tst = CTM_T_OBIAS;
        end else if (act_req && txd) begin
          nxt_st.tst = CTM_T_ACTIVE;
        end
      end
      // active: mode change first, then select, then supply
      CTM_T_ACTIVE: begin
        if (leave_req) begin
          nxt_st.tst = CTM_T_OBIAS;
        end else if (normal && sel_listen) begin
          nxt_st.tst = CTM_T_LISTEN;
        end else if (forced && !mcu_supply_ok) begin
          nxt_st.tst = CTM_T_LISTEN;
        end else if (normal && !mcu_supply_ok &&
                     st_ff.transceiver_mode_select == CTM_SEL_ACT_UV) begin
          nxt_st.tst = CTM_T_OBIAS;
        end
        // select 10 ignores undervoltage until the chip mode or the select field changes
      end
      default: nxt_st.tst = CTM_T_OFF;
    endcase
    // entering reset from off or overtemp restarts offline
    if (reset_entry) begin
      nxt_st.tst = CTM_T_OFFLINE;
    end
    // off conditions override everything, bus lines float
    if (off_cond) begin
      nxt_st.tst = CTM_T_OFF;
    end
    // bus pin controls registered from the next state so they never glitch
    nxt_st.tx_on = (nxt_st.tst == CTM_T_ACTIVE);
    nxt_st.bias_mid = (nxt_st.tst == CTM_T_ACTIVE) || (nxt_st.tst == CTM_T_LISTEN) ||
                      (nxt_st.tst == CTM_T_OBIAS);
    nxt_st.bias_low = (nxt_st.tst == CTM_T_OFFLINE);
    nxt_st.xcvr_on = (nxt_st.tst != CTM_T_OFF);

    // output switches; hv switch frozen in overtemp so loads stay supplied
    if (!chip_ot) begin
      nxt_st.hv_out = hv_on;
    end
    nxt_st.sens_out = hv_on && !chip_ot;
  end

  // the one state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.tst <= CTM_T_OFF;
      st_ff.wst <= CTM_W_IDLE;
      st_ff.rx_prev <= 1'b1;
      st_ff.load_pend <= 1'b1;
      st_ff.transceiver_mode_select <= CTM_MODE_SEL_RST;
      st_ff.bus_wake_detect_enable <= CTM_WAKE_EN_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // pins follow registered state; listen keeps bias with transmitter off
  assign prdata = st_ff.rdata;
  assign pready = st_ff.rdy;
  assign pslverr = st_ff.err;
  assign high_voltage_switch_output = st_ff.hv_out;
  assign sensor_supply_output = st_ff.sens_out;
  assign tx_enable = st_ff.tx_on;
  assign bias_2v5 = st_ff.bias_mid;
  assign bias_gnd = st_ff.bias_low;
  assign transceiver_on = st_ff.xcvr_on;
  assign rxd_force_low = st_ff.rxd_low;
  assign sleep_wake_request = st_ff.wake_req;

endmodule : ctm_mode_ctrl

// File: hdl/ctm_pkg.sv
// constants and types for the CAN transceiver mode controller
// assumes a 100 MHz pclk and an APB slave with 32-bit data
package ctm_pkg;
  localparam int CTM_CLK_NS = 10;
  // register byte offsets
  localparam logic [11:0] CTM_OUTCFG_ADDR = 12'h000;
  localparam logic [11:0] CTM_CANCTRL_ADDR = 12'h004;
  localparam logic [11:0] CTM_STATUS_ADDR = 12'h008;
  // field positions
  localparam int CTM_CANCTRL_WAKE_EN_BIT = 2;
  localparam int CTM_ST_TX_READY_BIT = 0;
  localparam int CTM_ST_SILENT_BIT = 1;
  localparam int CTM_ST_WAKE_EV_BIT = 2;
  localparam int CTM_ST_STATE_LSB = 4;
  // reset values
  localparam logic [1:0] CTM_MODE_SEL_RST = 2'h0;
  localparam logic CTM_WAKE_EN_RST = 1'b0;
  // chip operating modes as presented on chip_mode_control
  localparam logic [2:0] CTM_CHIP_OFF = 3'h0;
  localparam logic [2:0] CTM_CHIP_OVERTEMP = 3'h1;
  localparam logic [2:0] CTM_CHIP_RESET = 3'h2;
  localparam logic [2:0] CTM_CHIP_STANDBY = 3'h3;
  localparam logic [2:0] CTM_CHIP_SLEEP = 3'h4;
  localparam logic [2:0] CTM_CHIP_FORCED = 3'h5;
  localparam logic [2:0] CTM_CHIP_NORMAL = 3'h7;
  // transceiver mode select codes
  localparam logic [1:0] CTM_SEL_OFFLINE = 2'h0;
  localparam logic [1:0] CTM_SEL_ACT_UV = 2'h1;
  localparam logic [1:0] CTM_SEL_ACT_NOUV = 2'h2;
  localparam logic [1:0] CTM_SEL_LISTEN = 2'h3;
  // output configuration codes
  localparam logic [1:0] CTM_OUT_NEVER = 2'h0;
  localparam logic [1:0] CTM_OUT_NORMAL = 2'h1;
  localparam logic [1:0] CTM_OUT_AWAKE = 2'h2;
  localparam logic [1:0] CTM_OUT_ALWAYS = 2'h3;
  // timing, times in ns
  localparam int CTM_SILENCE_NS = 1000000;
  localparam int CTM_WAKE_TO_NS = 1000000;
  localparam int CTM_WAKE_DOM_NS = 500;
  localparam int CTM_WAKE_REC_NS = 500;
  localparam logic [19:0] CTM_SILENCE_CYC = 20'((CTM_SILENCE_NS + CTM_CLK_NS - 1) / CTM_CLK_NS);
  localparam logic [19:0] CTM_WAKE_TO_CYC = 20'(CTM_WAKE_TO_NS / CTM_CLK_NS);
  localparam logic [19:0] CTM_WAKE_DOM_CYC = 20'((CTM_WAKE_DOM_NS + CTM_CLK_NS - 1) / CTM_CLK_NS);
  localparam logic [19:0] CTM_WAKE_REC_CYC = 20'((CTM_WAKE_REC_NS + CTM_CLK_NS - 1) / CTM_CLK_NS);

  typedef enum logic [4:0] {
    CTM_T_OFF = 5'h01,
    CTM_T_OFFLINE = 5'h02,
    CTM_T_OBIAS = 5'h04,
    CTM_T_LISTEN = 5'h08,
    CTM_T_ACTIVE = 5'h10
  } ctm_tstate_t;

  typedef enum logic [3:0] {
    CTM_W_IDLE = 4'h1,
    CTM_W_DOM1 = 4'h2,
    CTM_W_REC = 4'h4,
    CTM_W_DOM2 = 4'h8
  } ctm_wstate_t;
endpackage : ctm_pkg
